// >>> core/asc_core.sv
// Asynchronous serial transceiver with format and enable control registers.
// Assumes one AHB-Lite master, single word transfers, and an rx pin from outside.
`timescale 1ns/10ps
`include "asc_regs.svh"

// How it works
// [RQ1] Module on forces the shared receive pin to be an input.
// [RQ2] Loopback feeds transmit line to receiver, only when both directions enabled.
// [RQ3] Module on runs baud; clearing forces empty and done flags, masks tx interrupt.
// [RQ4] Transmit inversion flips every level on the transmit line.
// [RQ5] Character length: 10-bit frames when clear, 11-bit when set.
// [RQ6] Parity sits in the top data position, leaving 7 or 8 data bits.
// [RQ7] Parity odd select: 1 odd, 0 even, for both transmit and receive.
// [RQ8] Software leaves parity type alone during a character.
// [RQ9] Wake select: 1 address mark wakes, 0 idle line wakes.
// [RQ10] Idle origin: 1 count ones after stop bit, 0 after start bit.
// [RQ11] Transmit empty interrupt enable gates empty flag onto tx request.
// [RQ12] Transmit done interrupt enable gates done flag onto tx request.
// [RQ13] Receive full interrupt enable gates full flag onto rx request.
// [RQ14] Line quiet interrupt enable gates idle flag onto rx request.
// [RQ15] Setting tx on sends a preamble of 10 or 11 ones.
// [RQ16] Clearing tx on finishes the current character, then line idles high.
// [RQ17] Clear then set tx on mid-character queues an idle character after it.
// [RQ18] Software writes tx on and rx on only while module is on.
// [RQ19] Clearing rx on stops the receiver, receive flags unchanged.
// [RQ20] Standby masks rx interrupts until wake condition, then self-clears.
// [RQ21] Break bit pulse sends one break then a 1; held sends back-to-back breaks.
// [RQ22] Software avoids toggling break right after the empty flag sets.
// [RQ23] Address mark wake clears standby and sets receive full.
// [RQ24] Idle wake character sets neither idle flag nor receive full.
// [RQ25] Reset clears every control bit of both control registers.
// [RQ26] Writes to tx on and rx on are ignored while module is off.
module asc_core #(
   parameter int BIT_DIV = 16
) (
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_n_i,
   input  wire asc_pkg::asc_ahb_req_type ahb_req_i,
   output logic                          hreadyout_o,
   output logic                          hresp_o,
   output logic [31:0]                   hrdata_o,
   input  wire logic                     rx_pin_i,
   output logic                          txd_o,
   output logic                          rx_pin_input_o,
   output logic                          tx_irq_o,
   output logic                          rx_irq_o
);
   import asc_pkg::*;

   logic [7:0]       format_ctl;
   logic [7:0]       enable_ctl;
   logic             tx_empty_flag;
   logic             tx_done_flag;
   logic             rx_full_flag;
   logic             idle_flag;
   logic             overrun_flag;
   logic             frame_flag;
   logic             parity_flag;
   logic [8:0]       tx_data;
   logic [8:0]       rx_data;
   logic [4:0]       flag_snap;
   logic             wr_pend;
   logic [7:0]       wr_addr;
   logic             rd_flags;
   logic             rd_data;
   logic             wr_data;
   logic [15:0]      baud_cnt;
   logic             baud_tick;
   asc_tx_state_type tx_state;
   logic [10:0]      tx_shift;
   logic [3:0]       tx_left;
   logic             tx_line;
   logic             tx_on_q;
   logic             preamble_pend;
   logic             break_tail;
   logic             tx_load_data;
   asc_rx_state_type rx_state;
   logic             rx_meta;
   logic             rx_sync;
   logic             rx_in;
   logic [15:0]      rx_cnt;
   logic [3:0]       rx_bit;
   logic [10:0]      rx_shift;
   logic [3:0]       ones_cnt;
   logic             idle_armed;
   logic             idle_hit;
   logic             rx_done;
   logic [8:0]       next_rx_char;
   logic             rx_msb;
   logic             rx_par_bad;

   wire module_on  = format_ctl[`ASC_FMT_MODULE];
   wire char9      = format_ctl[`ASC_FMT_CHAR9];
   wire parity_on  = format_ctl[`ASC_FMT_PARON];
   wire parity_odd = format_ctl[`ASC_FMT_PARODD];
   wire tx_on      = enable_ctl[`ASC_EN_TXON];
   wire rx_on      = enable_ctl[`ASC_EN_RXON];
   wire rx_standby = enable_ctl[`ASC_EN_STANDBY];
   wire break_send = enable_ctl[`ASC_EN_BREAK];
   wire [3:0] frame_len = char9 ? `ASC_FRAME_LONG : `ASC_FRAME_SHORT; // RQ5
   wire [15:0] bit_div  = 16'(BIT_DIV);

   // Bus slave: reads answer with zero wait, writes take one wait state
   wire addr_ok = ahb_req_i.hsel && ahb_req_i.htrans[1] && ahb_req_i.hready;
   assign rd_flags = addr_ok && !ahb_req_i.hwrite && ahb_req_i.haddr[7:0] == `ASC_OFS_FLAGS;
   assign rd_data  = addr_ok && !ahb_req_i.hwrite && ahb_req_i.haddr[7:0] == `ASC_OFS_DATA;
   assign wr_data  = wr_pend && wr_addr == `ASC_OFS_DATA;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_pend     <= 1'b0;
         wr_addr     <= 8'h00;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         hrdata_o    <= 32'h0000_0000;
      end else begin
         hresp_o <= 1'b0;
         wr_pend <= addr_ok && ahb_req_i.hwrite;
         if (addr_ok && ahb_req_i.hwrite) begin
            wr_addr     <= ahb_req_i.haddr[7:0];
            hreadyout_o <= 1'b0;
         end else begin
            hreadyout_o <= 1'b1;
         end
         if (addr_ok && !ahb_req_i.hwrite) begin
            case (ahb_req_i.haddr[7:0])
               `ASC_OFS_FORMAT: hrdata_o <= {24'h00_0000, format_ctl};
               `ASC_OFS_ENABLE: hrdata_o <= {24'h00_0000, enable_ctl};
               `ASC_OFS_FLAGS:  hrdata_o <= {24'h00_0000, tx_empty_flag, tx_done_flag,
                                             rx_full_flag, idle_flag, overrun_flag, 1'b0,
                                             frame_flag, parity_flag};
               `ASC_OFS_DATA:   hrdata_o <= {23'h00_0000, rx_data};
               default:         hrdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control registers
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         format_ctl <= `ASC_FORMAT_RESET; // RQ25
         enable_ctl <= `ASC_ENABLE_RESET; // RQ25
      end else begin
         if (wr_pend && wr_addr == `ASC_OFS_FORMAT) begin
            format_ctl <= ahb_req_i.hwdata[7:0];
         end
         if (wr_pend && wr_addr == `ASC_OFS_ENABLE) begin
            enable_ctl <= ahb_req_i.hwdata[7:0];
            if (!module_on) begin
               enable_ctl[`ASC_EN_TXON] <= tx_on; // RQ26
               enable_ctl[`ASC_EN_RXON] <= rx_on; // RQ26
            end
         end
         if (rx_standby && idle_hit && !format_ctl[`ASC_FMT_WAKEADR]) begin
            enable_ctl[`ASC_EN_STANDBY] <= 1'b0; // RQ20 RQ9
         end
         if (rx_standby && rx_done && format_ctl[`ASC_FMT_WAKEADR] && rx_msb) begin
            enable_ctl[`ASC_EN_STANDBY] <= 1'b0; // RQ23 RQ9
         end
      end
   end

   // Baud generator runs only while the module is on
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !module_on) begin // RQ3
         baud_cnt  <= 16'h0000;
         baud_tick <= 1'b0;
      end else begin
         baud_tick <= baud_cnt == bit_div - 16'h0001;
         baud_cnt  <= (baud_cnt == bit_div - 16'h0001) ? 16'h0000 : baud_cnt + 16'h0001;
      end
   end

   // Transmitter
   assign tx_load_data = tx_on && !tx_empty_flag && !preamble_pend && !break_send;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tx_state      <= ASC_TX_IDLE;
         tx_shift      <= 11'h7ff;
         tx_left       <= 4'h0;
         tx_line       <= 1'b1;
         tx_on_q       <= 1'b0;
         preamble_pend <= 1'b0;
         break_tail    <= 1'b0;
      end else if (!module_on) begin
         tx_state      <= ASC_TX_IDLE;
         tx_line       <= 1'b1;
         tx_on_q       <= tx_on;
         preamble_pend <= 1'b0;
         break_tail    <= 1'b0;
      end else begin
         tx_on_q <= tx_on;
         if (tx_on && !tx_on_q) begin
            preamble_pend <= 1'b1; // RQ15 RQ17
         end
         case (tx_state)
            ASC_TX_IDLE: begin
               if (baud_tick) begin
                  tx_line <= 1'b1; // RQ16
                  if (tx_on && break_send) begin
                     tx_shift      <= 11'h000; // RQ21 RQ22
                     tx_left       <= frame_len;
                     tx_state      <= ASC_TX_SHIFT;
                     break_tail    <= 1'b1;
                     preamble_pend <= 1'b0;
                  end else if (break_tail) begin
                     tx_shift   <= 11'h7ff; // RQ21
                     tx_left    <= 4'h1;
                     tx_state   <= ASC_TX_SHIFT;
                     break_tail <= 1'b0;
                  end else if (tx_on && preamble_pend) begin
                     tx_shift      <= 11'h7ff; // RQ15
                     tx_left       <= frame_len;
                     tx_state      <= ASC_TX_SHIFT;
                     preamble_pend <= 1'b0;
                  end else if (tx_load_data) begin
                     tx_shift <= char9 ?
                        {1'b1, parity_on ? (^tx_data[7:0]) ^ parity_odd : tx_data[8],
                         tx_data[7:0], 1'b0} : // RQ6 RQ7
                        {2'b11, parity_on ? (^tx_data[6:0]) ^ parity_odd : tx_data[7],
                         tx_data[6:0], 1'b0}; // RQ6 RQ7
                     tx_left  <= frame_len;
                     tx_state <= ASC_TX_SHIFT;
                  end
               end
            end
            ASC_TX_SHIFT: begin
               if (baud_tick) begin
                  tx_line  <= tx_shift[0];
                  tx_shift <= {1'b1, tx_shift[10:1]};
                  tx_left  <= tx_left - 4'h1;
                  if (tx_left == 4'h1) begin
                     tx_state <= ASC_TX_IDLE;
                     if (break_tail && break_send && tx_on) begin
                        tx_shift   <= 11'h000; // RQ21
                        tx_left    <= frame_len;
                        tx_state   <= ASC_TX_SHIFT;
                     end
                  end
               end
            end
            default: tx_state <= ASC_TX_IDLE;
         endcase
      end
   end

   // Transmit flags and holding register
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tx_empty_flag <= 1'b1;
         tx_done_flag  <= 1'b1;
         tx_data       <= 9'h000;
      end else if (!module_on) begin
         tx_empty_flag <= 1'b1; // RQ3
         tx_done_flag  <= 1'b1; // RQ3
      end else begin
         if (wr_data) begin
            tx_data       <= ahb_req_i.hwdata[8:0];
            tx_empty_flag <= 1'b0;
         end
         if (tx_state == ASC_TX_IDLE && baud_tick && tx_load_data) begin
            tx_empty_flag <= 1'b1;
         end
         tx_done_flag <= tx_empty_flag && !wr_data && tx_state == ASC_TX_IDLE &&
                         !preamble_pend && !break_tail && !(tx_on && break_send);
      end
   end

   // Receiver input: two-flop synchroniser, then loopback select
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else begin
         rx_meta <= rx_pin_i;
         rx_sync <= rx_meta;
      end
   end

   assign rx_in = (format_ctl[`ASC_FMT_LOOPBACK] && tx_on && rx_on) ?
                  tx_line : rx_sync; // RQ2

   assign next_rx_char = char9 ? rx_shift[9:1] : {1'b0, rx_shift[9:2]};
   assign rx_msb       = rx_shift[9];
   assign rx_par_bad   = parity_on &&
                         ((char9 ? ^rx_shift[9:1] : ^rx_shift[9:2]) != parity_odd); // RQ7

   // Receiver sequencer
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !module_on || !rx_on) begin // RQ19
         rx_state <= ASC_RX_IDLE;
         rx_cnt   <= 16'h0000;
         rx_bit   <= 4'h0;
         rx_shift <= 11'h7ff;
         rx_done  <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         case (rx_state)
            ASC_RX_IDLE: begin
               if (!rx_in) begin
                  rx_cnt   <= 16'h0000;
                  rx_state <= ASC_RX_START;
               end
            end
            ASC_RX_START: begin
               rx_cnt <= rx_cnt + 16'h0001;
               if (rx_cnt == (bit_div >> 1)) begin
                  rx_cnt   <= 16'h0000;
                  rx_bit   <= 4'h1;
                  rx_state <= rx_in ? ASC_RX_IDLE : ASC_RX_BITS;
               end
            end
            ASC_RX_BITS: begin
               rx_cnt <= rx_cnt + 16'h0001;
               if (rx_cnt == bit_div - 16'h0001) begin
                  rx_cnt   <= 16'h0000;
                  rx_shift <= {rx_in, rx_shift[10:1]};
                  rx_bit   <= rx_bit + 4'h1;
                  if (rx_bit == frame_len - 4'h1) begin
                     rx_done  <= 1'b1;
                     rx_state <= ASC_RX_IDLE;
                  end
               end
            end
            default: rx_state <= ASC_RX_IDLE;
         endcase
      end
   end

   // Idle counter: ones at bit rate, origin after start or after stop
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !module_on || !rx_on) begin
         ones_cnt <= 4'h0;
         idle_hit <= 1'b0;
      end else begin
         idle_hit <= 1'b0;
         if (rx_state == ASC_RX_START) begin
            ones_cnt <= 4'h0;
         end else if (rx_state == ASC_RX_BITS) begin
            if (rx_cnt == bit_div - 16'h0001) begin
               if (format_ctl[`ASC_FMT_IDLEORG] || !rx_in) begin
                  ones_cnt <= 4'h0; // RQ10
               end else begin
                  ones_cnt <= ones_cnt + 4'h1; // RQ10
               end
            end
         end else if (baud_tick && ones_cnt != frame_len) begin
            ones_cnt <= rx_in ? ones_cnt + 4'h1 : 4'h0;
            idle_hit <= rx_in && ones_cnt == frame_len - 4'h1;
         end
      end
   end

   // Receive flags; a set in the same cycle as a clear wins
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rx_full_flag <= 1'b0;
         idle_flag    <= 1'b0;
         overrun_flag <= 1'b0;
         frame_flag   <= 1'b0;
         parity_flag  <= 1'b0;
         rx_data      <= 9'h000;
         flag_snap    <= 5'h00;
         idle_armed   <= 1'b0;
      end else begin
         if (rd_flags) begin
            flag_snap <= {rx_full_flag, idle_flag, overrun_flag, frame_flag, parity_flag};
         end
         if (rd_data) begin
            rx_full_flag <= rx_full_flag & ~flag_snap[4];
            idle_flag    <= idle_flag & ~flag_snap[3];
            overrun_flag <= overrun_flag & ~flag_snap[2];
            frame_flag   <= frame_flag & ~flag_snap[1];
            parity_flag  <= parity_flag & ~flag_snap[0];
            flag_snap    <= 5'h00;
            if (flag_snap[3]) begin
               idle_armed <= 1'b0;
            end
         end
         if (rx_done && (!rx_standby || (format_ctl[`ASC_FMT_WAKEADR] && rx_msb))) begin
            if (rx_full_flag && !(rd_data && flag_snap[4])) begin
               overrun_flag <= 1'b1;
            end else begin
               rx_data      <= next_rx_char;
               rx_full_flag <= 1'b1; // RQ23
               frame_flag   <= !rx_shift[10];
               parity_flag  <= rx_par_bad; // RQ6
               idle_armed   <= 1'b1;
            end
         end
         if (idle_hit && !rx_standby && idle_armed) begin
            idle_flag  <= 1'b1; // RQ24
            idle_armed <= 1'b0;
         end
      end
   end

   // Pin direction and interrupt requests
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         txd_o          <= 1'b1;
         rx_pin_input_o <= 1'b0;
         tx_irq_o       <= 1'b0;
         rx_irq_o       <= 1'b0;
      end else begin
         txd_o          <= (module_on ? tx_line : 1'b1) ^ format_ctl[`ASC_FMT_TX_INVERT]; // RQ4
         rx_pin_input_o <= module_on; // RQ1
         tx_irq_o       <= module_on && // RQ3
                           ((enable_ctl[`ASC_EN_TXEIE] && tx_empty_flag) || // RQ11
                            (enable_ctl[`ASC_EN_TXDIE] && tx_done_flag)); // RQ12
         rx_irq_o       <= !rx_standby && // RQ20
                           ((enable_ctl[`ASC_EN_RXFIE] && rx_full_flag) || // RQ13
                            (enable_ctl[`ASC_EN_QUIETIE] && idle_flag)); // RQ14
      end
   end

endmodule : asc_core

// >>> core/asc_pkg.sv
// Types shared by the serial control block.
// Assumes nothing of its surroundings.
package asc_pkg;

   typedef struct packed {
      logic        hsel;
      logic [1:0]  htrans;
      logic [31:0] haddr;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } asc_ahb_req_type;

   typedef enum logic [1:0] {
      ASC_TX_IDLE  = 2'b01,
      ASC_TX_SHIFT = 2'b10
   } asc_tx_state_type;

   typedef enum logic [2:0] {
      ASC_RX_IDLE  = 3'b001,
      ASC_RX_START = 3'b010,
      ASC_RX_BITS  = 3'b100
   } asc_rx_state_type;

endpackage : asc_pkg

// >>> core/asc_regs.svh
// Register offsets, field positions and reset values of the serial control block.
// Assumes byte addressing on a 32-bit AHB-Lite bus, one register per aligned word.
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

`define ASC_OFS_FORMAT   8'h00
`define ASC_OFS_ENABLE   8'h04
`define ASC_OFS_FLAGS    8'h08
`define ASC_OFS_DATA     8'h0c

// Format control fields
`define ASC_FMT_LOOPBACK 7
`define ASC_FMT_MODULE   6
`define ASC_FMT_TX_INVERT    5
`define ASC_FMT_CHAR9    4
`define ASC_FMT_WAKEADR  3
`define ASC_FMT_IDLEORG  2
`define ASC_FMT_PARON    1
`define ASC_FMT_PARODD   0

// Enable and interrupt control fields
`define ASC_EN_TXEIE     7
`define ASC_EN_TXDIE     6
`define ASC_EN_RXFIE     5
`define ASC_EN_QUIETIE   4
`define ASC_EN_TXON      3
`define ASC_EN_RXON      2
`define ASC_EN_STANDBY   1
`define ASC_EN_BREAK     0

// Flag register fields
`define ASC_FL_TXEMPTY   7
`define ASC_FL_TXDONE    6
`define ASC_FL_RXFULL    5
`define ASC_FL_IDLE      4
`define ASC_FL_OVERRUN   3
`define ASC_FL_FRAME     1
`define ASC_FL_PARITY    0

`define ASC_FORMAT_RESET 8'h00
`define ASC_ENABLE_RESET 8'h00
`define ASC_FRAME_SHORT  4'ha
`define ASC_FRAME_LONG   4'hb

`endif

// >>> verif/asc_core_sva.sv
// Checker for the serial control block, watching its ports only.
// Assumes one AHB-Lite master and the register offsets of the block.
`timescale 1ns/10ps
module asc_core_sva #(
   parameter int BIT_DIV = 16
) (
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_n_i,
   input  wire asc_pkg::asc_ahb_req_type ahb_req_i,
   input  wire logic                     hreadyout_o,
   input  wire logic                     hresp_o,
   input  wire logic [31:0]              hrdata_o,
   input  wire logic                     rx_pin_i,
   input  wire logic                     txd_o,
   input  wire logic                     rx_pin_input_o,
   input  wire logic                     tx_irq_o,
   input  wire logic                     rx_irq_o
);
   import asc_pkg::*;
   logic [7:0] fmt, en, ad;
   logic       wp;
   wire        tk = ahb_req_i.hsel && ahb_req_i.htrans[1] && ahb_req_i.hready;
   wire        cm = wp && !hreadyout_o;
   wire        rd = tk && !ahb_req_i.hwrite;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wp <= 1'b0;
         ad <= 8'h00;
      end else if (tk) begin
         wp <= ahb_req_i.hwrite;
         ad <= ahb_req_i.haddr[7:0];
      end else if (hreadyout_o) begin
         wp <= 1'b0;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) fmt <= 8'h00;
      else if (cm && ad == 8'h00) fmt <= ahb_req_i.hwdata[7:0];
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) en <= 8'h00;
      else if (cm && ad == 8'h04) en <= fmt[6] ? ahb_req_i.hwdata[7:0] :
         {ahb_req_i.hwdata[7:4], en[3:2], ahb_req_i.hwdata[1:0]};
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_wr;
      tk && ahb_req_i.hwrite;
   endsequence
   sequence s_wr_ans;
      !hreadyout_o ##1 hreadyout_o;
   endsequence
   sequence s_off;
      (!fmt[6] && $stable(fmt[5]))[*4];
   endsequence
   chk_write_wait: assert property (s_wr |=> s_wr_ans)
      else $error("write wait state wrong");
   chk_read_nowait: assert property (rd |=> hreadyout_o && !hresp_o)
      else $error("read not answered at once");
   chk_fmt_read: assert property (
      rd && ahb_req_i.haddr[7:0] == 8'h00 |=> hrdata_o == {24'h0, fmt})
      else $error("format readback wrong");
   chk_en_read: assert property (
      rd && ahb_req_i.haddr[7:0] == 8'h04 |=> (hrdata_o & 32'hfd) == {24'h0, en & 8'hfd})
      else $error("enable readback wrong");
   chk_pin_input: assert property ($stable(fmt[6]) |-> rx_pin_input_o == fmt[6])
      else $error("receive pin direction wrong");
   chk_tx_off: assert property (!fmt[6] && !$past(fmt[6]) |-> !tx_irq_o)
      else $error("tx request while module off");
   chk_tx_masked: assert property (
      en[7:6] == 2'b00 && $past(en[7:6]) == 2'b00 |-> !tx_irq_o)
      else $error("tx request while masked");
   chk_rx_masked: assert property (
      en[5:4] == 2'b00 && $past(en[5:4]) == 2'b00 |-> !rx_irq_o)
      else $error("rx request while masked");
   chk_quiet_line: assert property (s_off |-> txd_o == !fmt[5])
      else $error("tx line not idle");
endmodule : asc_core_sva
bind asc_core asc_core_sva #(.BIT_DIV(BIT_DIV)) u_sva (.core_clk_i(core_clk_i),
   .rst_n_i(rst_n_i), .ahb_req_i(ahb_req_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .hrdata_o(hrdata_o), .rx_pin_i(rx_pin_i), .txd_o(txd_o),
   .rx_pin_input_o(rx_pin_input_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));

// >>> verif/asc_core_tb_top.sv
// Bench for the serial control block: registers, frames and interrupts.
// Assumes the core, its checker and the remote model are compiled first.
`timescale 1ns/10ps
`include "asc_regs.svh"
module asc_core_tb_top;
   import asc_pkg::*;
   localparam int BD = 4;
   logic            core_clk_i;
   logic            rst_n_i;
   asc_ahb_req_type bus;
   asc_ahb_req_type ahb;
   logic            hreadyout_o;
   logic            hresp_o;
   logic [31:0]     hrdata_o;
   logic            rx_pin;
   logic            txd_o;
   logic            rx_in;
   logic            tx_irq_o;
   logic            rx_irq_o;
   int              mismatches, cmp_count, w;
   logic [10:0]     g;
   logic [8:0]      d;
   logic            c9, pon, pod, inv;
   always_comb begin
      ahb = bus;
      ahb.hready = hreadyout_o;
   end
   asc_core #(.BIT_DIV(BD)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .ahb_req_i(ahb), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
      .rx_pin_i(rx_pin), .txd_o(txd_o), .rx_pin_input_o(rx_in), .tx_irq_o(tx_irq_o),
      .rx_irq_o(rx_irq_o));
   asc_remote_model #(.BIT_DIV(BD)) u_peer (.core_clk_i(core_clk_i), .rx_pin_o(rx_pin));
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic tick(inout int c);
      @(posedge core_clk_i);
      c++;
      if (c > 3000) begin
         mismatches++;
         $display("Error wait ran out");
         report_and_stop();
      end
   endtask : tick
   task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat);
      int c;
      c = 0;
      bus.hsel <= 1'b1;
      bus.htrans <= 2'h2;
      bus.haddr <= {24'h0, a};
      bus.hwrite <= wr_en;
      bus.hsize <= 3'h2;
      do tick(c); while (hreadyout_o !== 1'b1);
      bus.htrans <= 2'h0;
      bus.hwdata <= wd;
      do tick(c); while (hreadyout_o !== 1'b1);
      rdat = hrdata_o;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] r;
      xfer(1'b1, a, wd, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk($sformatf("reg %h", a), e, r & m);
   endtask : rd
   task automatic cap(input logic lv, input int n, output logic [10:0] f, output int c);
      f = '0;
      c = 0;
      while (txd_o !== !lv) tick(c);
      while (txd_o !== lv) tick(c);
      repeat (BD / 2) @(posedge core_clk_i);
      for (int i = 0; i < n; i++) begin
         f[i] = txd_o;
         repeat (BD) @(posedge core_clk_i);
      end
   endtask : cap
   function automatic logic [10:0] frm(input logic [8:0] v, input logic l9, pe, po, iv);
      int          nd;
      logic [8:0]  x;
      logic [10:0] f;
      nd = l9 ? 9 : 8;
      x = l9 ? v : {1'b0, v[7:0]};
      if (pe) x[nd-1] = ^(x & ~(9'h1 << (nd - 1))) ^ po;
      f = {1'b0, x, 1'b0} | (11'h1 << (nd + 1));
      return f ^ ((l9 ? 11'h7ff : 11'h3ff) & {11{iv}});
   endfunction : frm
   task automatic irq(input logic [7:0] v, input logic e);
      wr(`ASC_OFS_ENABLE, {24'h0, v});
      repeat (2) @(posedge core_clk_i);
      chk("tx request", {31'h0, e}, {31'h0, tx_irq_o});
   endtask : irq
   initial begin
      bus = '0;
      rst_n_i = 1'b0;
      mismatches = 0;
      cmp_count = 0;
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      rd(`ASC_OFS_FORMAT, 32'hff, 32'h00);
      rd(`ASC_OFS_ENABLE, 32'hff, 32'h00);
      rd(8'h10, 32'hffffffff, 32'h0);
      wr(`ASC_OFS_ENABLE, 32'h0c);
      rd(`ASC_OFS_ENABLE, 32'hff, 32'h00);
      chk("pin input", 32'h0, {31'h0, rx_in});
      wr(`ASC_OFS_FORMAT, 32'h40);
      wr(`ASC_OFS_ENABLE, 32'h0c);
      chk("pin input", 32'h1, {31'h0, rx_in});
      rd(`ASC_OFS_ENABLE, 32'hff, 32'h0c);
      for (int k = 0; k < 6; k++) begin
         c9 = k[0];
         pon = k > 1;
         pod = k > 3;
         inv = k == 5;
         d = 9'h0a5 + 9'(k * 77);
         wr(`ASC_OFS_FORMAT, {26'h1, inv, c9, 2'b00, pon, pod});
         wr(`ASC_OFS_DATA, {23'h0, d});
         fork
            cap(inv, c9 ? 11 : 10, g, w);
            if (inv) begin
               repeat (3 * BD) @(posedge core_clk_i);
               wr(`ASC_OFS_ENABLE, 32'h00);
            end
         join
         chk("frame", {21'h0, frm(d, c9, pon, pod, inv)}, {21'h0, g});
         if (k == 0) chk("preamble", 32'h1, {31'h0, w > 8 * BD});
         repeat (BD) @(posedge core_clk_i);
      end
      repeat (2 * BD) @(posedge core_clk_i);
      chk("idle line", {31'h0, !inv}, {31'h0, txd_o});
      rd(`ASC_OFS_FLAGS, 32'hc0, 32'hc0);
      irq(8'h40, 1'b1);
      irq(8'h80, 1'b1);
      irq(8'h00, 1'b0);
      wr(`ASC_OFS_FORMAT, 32'h00);
      irq(8'hc0, 1'b0);
      rd(`ASC_OFS_FLAGS, 32'hc0, 32'hc0);
      wr(`ASC_OFS_FORMAT, 32'h58);
      wr(`ASC_OFS_ENABLE, 32'h26);
      u_peer.send({1'b1, 9'h055, 1'b0});
      repeat (2 * BD) @(posedge core_clk_i);
      chk("rx request", 32'h0, {31'h0, rx_irq_o});
      rd(`ASC_OFS_FLAGS, 32'h20, 32'h00);
      u_peer.send({1'b1, 9'h155, 1'b0});
      repeat (2 * BD) @(posedge core_clk_i);
      chk("rx request", 32'h1, {31'h0, rx_irq_o});
      rd(`ASC_OFS_ENABLE, 32'hff, 32'h24);
      wr(`ASC_OFS_ENABLE, 32'h20);
      rd(`ASC_OFS_FLAGS, 32'h20, 32'h20);
      rd(`ASC_OFS_DATA, 32'h1ff, 32'h155);
      repeat (2) @(posedge core_clk_i);
      chk("rx request", 32'h0, {31'h0, rx_irq_o});
      wr(`ASC_OFS_FORMAT, 32'hc2);
      wr(`ASC_OFS_ENABLE, 32'h0c);
      wr(`ASC_OFS_DATA, 32'h3c);
      repeat (30 * BD) @(posedge core_clk_i);
      rd(`ASC_OFS_DATA, 32'h1ff, 32'h03c);
      report_and_stop();
   end
endmodule : asc_core_tb_top

// >>> verif/asc_remote_model.sv
// Remote serial transmitter driving the receive pin of the serial block.
// Assumes the bench clock and the same bit time as the block.
`timescale 1ns/10ps
module asc_remote_model #(
   parameter int BIT_DIV = 16
) (
   input  wire logic core_clk_i,
   output logic      rx_pin_o
);
   initial rx_pin_o = 1'b1;
   // Frame leaves LSB first, one bit time each; stop bit leaves line high
   task automatic send(input logic [10:0] f);
      for (int i = 0; i < 11; i++) begin
         @(posedge core_clk_i);
         rx_pin_o <= f[i];
         repeat (BIT_DIV - 1) @(posedge core_clk_i);
      end
   endtask : send
endmodule : asc_remote_model
